// *** dv/smac_config_regs_properties.sv ***
// Concurrent checks for the modulator and bias-loop register bank.
`timescale 1ns/1ps
module smac_config_regs_properties (
   input wire CLOCK,
   input wire RST,
   input wire CE,
   input wire PWRITE,
   input wire PSLVERR,
   input wire [31:0] PRDATA,
   input wire FRACTION_WORD_WRITE,
   input wire MODULATOR_RESET,
   input wire MODULATOR_RESET_MASK,
   input wire HALF_LSB_ADD,
   input wire AUX_MODULATOR_ON,
   input wire [7:0] VCO_STATUS_DATA,
   input wire [7:0] VERSION_DATA,
   input wire [7:0] READBACK_DATA,
   input wire READBACK_VERSION
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   AST_FRAC_RESET: assert property (
      FRACTION_WORD_WRITE && CE && !MODULATOR_RESET_MASK |=> MODULATOR_RESET)
      else $error("missing modulator reset");
   AST_FRAC_MASKED: assert property (
      FRACTION_WORD_WRITE && CE && MODULATOR_RESET_MASK |=> !MODULATOR_RESET)
      else $error("masked reset fired");
   AST_RESET_CAUSE: assert property (
      MODULATOR_RESET && $past(CE) |-> $past(FRACTION_WORD_WRITE))
      else $error("reset without write");
   AST_HALF_LSB: assert property (
      HALF_LSB_ADD |-> !AUX_MODULATOR_ON) else $error("half lsb with aux");
   AST_RB_VERSION: assert property (
      CE && READBACK_VERSION |=> READBACK_DATA == $past(VERSION_DATA))
      else $error("bad version readback");
   AST_RB_STATUS: assert property (
      CE && !READBACK_VERSION |=> READBACK_DATA == $past(VCO_STATUS_DATA))
      else $error("bad status readback");
   AST_UNMAPPED_READ: assert property (
      PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("unmapped data");
   AST_UPPER_ZERO: assert property (
      PRDATA[31:8] == 24'h0) else $error("upper read bits set");
   C_RESET: cover property (MODULATOR_RESET);
   C_HALF: cover property (HALF_LSB_ADD);
   C_ERR: cover property (PSLVERR);
endmodule // smac_config_regs_properties
bind smac_config_regs smac_config_regs_properties i_props (.CLOCK(CLOCK),
   .RST(RST), .CE(CE), .PWRITE(PWRITE), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
   .FRACTION_WORD_WRITE(FRACTION_WORD_WRITE),
   .MODULATOR_RESET(MODULATOR_RESET),
   .MODULATOR_RESET_MASK(MODULATOR_RESET_MASK), .HALF_LSB_ADD(HALF_LSB_ADD),
   .AUX_MODULATOR_ON(AUX_MODULATOR_ON), .VCO_STATUS_DATA(VCO_STATUS_DATA),
   .VERSION_DATA(VERSION_DATA), .READBACK_DATA(READBACK_DATA),
   .READBACK_VERSION(READBACK_VERSION));

// *** dv/tb.sv ***
// Self-checking bench for the modulator and bias-loop register bank.
`timescale 1ns/1ps
module tb;
   reg clock = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, fw = 0;
   reg [7:0] paddr = 0;
   reg [31:0] pwdata = 0, rd;
   reg err;
   wire pready, pslverr, mr;
   wire [31:0] prdata;
   wire [7:0] rb;
   wire [2:0] bl;
   wire [3:0] md;
   wire [6:0] cd;
   wire [4:0] cc, cb;
   integer err_count = 0, samples_checked = 0, i;
   localparam logic [21:0] ROWS [10] = '{{6'h2a, 8'hff, 8'h29},
      {6'h2b, 8'hff, 8'h35}, {6'h2c, 8'hff, 8'h7f}, {6'h2d, 8'hff, 8'h1f},
      {6'h2e, 8'hff, 8'h1f}, {6'h2a, 8'h29, 8'h29}, {6'h2b, 8'h24, 8'h24},
      {6'h2c, 8'h6b, 8'h6b}, {6'h2d, 8'h0a, 8'h0a}, {6'h2e, 8'h16, 8'h16}};
   localparam logic [7:0] RST_VAL [5] = '{8'h00, 8'h01, 8'h44, 8'h11, 8'h10};
   smac_config_regs i_dut (.CLOCK(clock), .RST(rst), .CE(ce), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(4'hf), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
      .FRACTION_WORD_WRITE(fw), .VCO_STATUS_DATA(8'ha5), .VERSION_DATA(8'h5a),
      .READBACK_DATA(rb), .READBACK_VERSION(bl[0]), .BLEED_POSITIVE(bl[2]),
      .RESERVED_LATCH_CHOICE(bl[1]), .MODULATOR_OFF_INTEGER(md[0]),
      .AUX_MODULATOR_ON(md[2]), .HALF_LSB_ADD(md[3]),
      .MODULATOR_RESET_MASK(md[1]), .MODULATOR_RESET(mr),
      .BIAS_LOOP_OFF(cd[0]), .TEMP_CAL_VOLTAGE_ON(cd[1]),
      .RECTIFIER_BIAS_CORE_D(cd[6]), .LOW_THRESHOLD_CORE_D(cd[5]),
      .THRESHOLD_CODE_CORE_D(cd[4:2]), .RECTIFIER_BIAS_CORE_C(cc[4]),
      .LOW_THRESHOLD_CORE_C(cc[3]), .THRESHOLD_CODE_CORE_C(cc[2:0]),
      .RECTIFIER_BIAS_CORE_B(cb[4]), .LOW_THRESHOLD_CORE_B(cb[3]),
      .THRESHOLD_CODE_CORE_B(cb[2:0]));
   initial forever #50 clock = ~clock;
   task chk(input [7:0] got, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Each transfer starts one edge after the last, so no signal is set twice.
   task apb(input w, input [5:0] idx, input [7:0] d);
      begin
         @(posedge clock);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= {idx, 2'b00};
         pwdata <= {24'h0, d};
         @(posedge clock);
         penable <= 1'b1;
         @(posedge clock);
         while (pready !== 1'b1) @(posedge clock);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task pulse(input [7:0] exp);
      begin
         @(posedge clock);
         fw <= 1'b1;
         @(posedge clock);
         fw <= 1'b0;
         @(negedge clock);
         chk({7'h0, mr}, exp);
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      repeat (3000) @(posedge clock);
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 10; i = i + 1) begin
         apb(1'b1, ROWS[i][21:16], ROWS[i][15:8]);
         apb(1'b0, ROWS[i][21:16], 8'h00);
         chk(rd[7:0], ROWS[i][7:0]);
      end
      @(negedge clock);
      chk({1'b0, bl, md}, 8'h7a);
      chk({1'b0, cd}, 8'h6b);
      chk({3'h0, cc}, 8'h0a);
      chk({3'h0, cb}, 8'h16);
      chk(rb, 8'h5a);
      pulse(8'h00);
      apb(1'b1, 6'h2a, 8'h00);
      apb(1'b1, 6'h2b, 8'h30);
      @(negedge clock);
      chk(rb, 8'ha5);
      chk({4'h0, md}, 8'h04);
      pulse(8'h01);
      apb(1'b0, 6'h29, 8'h00);
      chk({7'h0, err}, 8'h01);
      chk(rd[7:0], 8'h00);
      ce <= 1'b0;
      pulse(8'h00);
      @(posedge clock);
      ce <= 1'b1;
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
         apb(1'b0, ROWS[i][21:16], 8'h00);
         chk(rd[7:0], RST_VAL[i]);
      end
      give_verdict;
   end
endmodule // tb

// *** logic/smac_config_regs.v ***
// APB register bank for modulator control and VCO bias-loop settings.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "smac_regs.vh"

module smac_config_regs #(
   parameter ADDR_WIDTH = 8
) (
   input wire CLOCK,
   input wire RST,
   input wire CE,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [ADDR_WIDTH-1:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [3:0] PSTRB,
   output wire PREADY,
   output wire PSLVERR,
   output wire [31:0] PRDATA,
   input wire FRACTION_WORD_WRITE,
   input wire [7:0] VCO_STATUS_DATA,
   input wire [7:0] VERSION_DATA,
   output wire [7:0] READBACK_DATA,
   output wire READBACK_VERSION,
   output wire BLEED_POSITIVE,
   output wire RESERVED_LATCH_CHOICE,
   output wire MODULATOR_OFF_INTEGER,
   output wire AUX_MODULATOR_ON,
   output wire HALF_LSB_ADD,
   output wire MODULATOR_RESET_MASK,
   output wire MODULATOR_RESET,
   output wire BIAS_LOOP_OFF,
   output wire TEMP_CAL_VOLTAGE_ON,
   output wire RECTIFIER_BIAS_CORE_D,
   output wire LOW_THRESHOLD_CORE_D,
   output wire [2:0] THRESHOLD_CODE_CORE_D,
   output wire RECTIFIER_BIAS_CORE_C,
   output wire LOW_THRESHOLD_CORE_C,
   output wire [2:0] THRESHOLD_CODE_CORE_C,
   output wire RECTIFIER_BIAS_CORE_B,
   output wire LOW_THRESHOLD_CORE_B,
   output wire [2:0] THRESHOLD_CODE_CORE_B
);

   // Maps a bus address onto a slot of the bank, or none.
   function [2:0] slot_of;
      input [ADDR_WIDTH-1:0] addr;
      reg [5:0] idx;
      begin
         idx = addr[7:2];
         slot_of = `SMAC_SLOT_NONE;
         if (addr[1:0] == 2'h0) begin
            case (idx)
               `SMAC_IDX_BLEED: slot_of = `SMAC_SLOT_BLEED;
               `SMAC_IDX_MOD: slot_of = `SMAC_SLOT_MOD;
               `SMAC_IDX_CORE_D: slot_of = `SMAC_SLOT_CORE_D;
               `SMAC_IDX_CORE_C: slot_of = `SMAC_SLOT_CORE_C;
               `SMAC_IDX_CORE_B: slot_of = `SMAC_SLOT_CORE_B;
               default: slot_of = `SMAC_SLOT_NONE;
            endcase
         end
      end
   endfunction

   // Reset value of a slot.
   function [7:0] reset_of;
      input [2:0] slot;
      begin
         case (slot)
            `SMAC_SLOT_BLEED: reset_of = `SMAC_RST_BLEED;
            `SMAC_SLOT_MOD: reset_of = `SMAC_RST_MOD;
            `SMAC_SLOT_CORE_D: reset_of = `SMAC_RST_CORE_D;
            `SMAC_SLOT_CORE_C: reset_of = `SMAC_RST_CORE_C;
            `SMAC_SLOT_CORE_B: reset_of = `SMAC_RST_CORE_B;
            default: reset_of = 8'h00;
         endcase
      end
   endfunction

   // Contents of a slot as seen on the read path. Any code outside the
   // bank reads as zero, so an unmapped address never indexes past the end
   // of the flattened bank.
   function [7:0] read_of;
      input [2:0] sel;
      input [8*`SMAC_SLOTS-1:0] regs;
      begin
         case (sel)
            `SMAC_SLOT_BLEED: read_of = regs[7:0];
            `SMAC_SLOT_MOD: read_of = regs[15:8];
            `SMAC_SLOT_CORE_D: read_of = regs[23:16];
            `SMAC_SLOT_CORE_C: read_of = regs[31:24];
            `SMAC_SLOT_CORE_B: read_of = regs[39:32];
            default: read_of = 8'h00;
         endcase
      end
   endfunction

   // Writable bits of a slot.
   function [7:0] wmask_of;
      input [2:0] slot;
      begin
         case (slot)
            `SMAC_SLOT_BLEED: wmask_of = `SMAC_WMASK_BLEED;
            `SMAC_SLOT_MOD: wmask_of = `SMAC_WMASK_MOD;
            `SMAC_SLOT_CORE_D: wmask_of = `SMAC_WMASK_CORE_D;
            `SMAC_SLOT_CORE_C: wmask_of = `SMAC_WMASK_CORE_C;
            `SMAC_SLOT_CORE_B: wmask_of = `SMAC_WMASK_CORE_B;
            default: wmask_of = 8'h00;
         endcase
      end
   endfunction

   wire [2:0] slot = slot_of(PADDR);
   wire mapped = (slot != `SMAC_SLOT_NONE);
   wire setup = PSEL & ~PENABLE & CE;
   wire access = PSEL & PENABLE & CE;
   // Byte lane 0 carries the whole register; other lanes are ignored.
   wire write_hit = access & PWRITE & mapped & PSTRB[0];
   wire [`SMAC_SLOTS-1:0] slot_write;
   wire [8*`SMAC_SLOTS-1:0] bank;
   wire [8*`SMAC_SLOTS-1:0] next_bank;
   reg [7:0] read_word;
   reg [7:0] readback;
   reg mod_reset;
   reg half_lsb;

   localparam [7:0] RST_MOD = `SMAC_RST_MOD;
   // Value of the gated half-LSB output while reset holds the bank.
   localparam [0:0] RST_HALF = RST_MOD[`SMAC_BIT_HALF_LSB] &
                               ~RST_MOD[`SMAC_BIT_AUX_ON];

   genvar g;

   // One write strobe per slot keeps the address decode out of the
   // register loop below.
   generate
      for (g = 0; g < `SMAC_SLOTS; g = g + 1) begin : slot_dec
         localparam [2:0] SLOT_ID = g;
         assign slot_write[g] = write_hit & (slot == SLOT_ID);
      end
   endgenerate

   generate
      for (g = 0; g < `SMAC_SLOTS; g = g + 1) begin : slot_reg
         localparam [2:0] SLOT_ID = g;
         reg [7:0] value;
         reg [7:0] next_value;
         always @* begin
            next_value = value;
            if (slot_write[g]) begin
               next_value = PWDATA[7:0] & wmask_of(SLOT_ID);
            end
         end
         always @(posedge CLOCK or posedge RST) begin
            if (RST) begin
               value <= reset_of(SLOT_ID);
            end else if (CE) begin
               value <= next_value;
            end
         end
         assign bank[8*g+7:8*g] = value;
         assign next_bank[8*g+7:8*g] = next_value;
      end
   endgenerate

   wire [7:0] reg_bleed = bank[7:0];
   wire [7:0] reg_mod = bank[15:8];
   wire [7:0] reg_core_d = bank[23:16];
   wire [7:0] reg_core_c = bank[31:24];
   wire [7:0] reg_core_b = bank[39:32];
   wire [7:0] next_mod = next_bank[15:8];

   // Read data is captured in the setup cycle so that it comes from a flop
   // without costing a wait state.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         read_word <= 8'h00;
      end else if (setup) begin
         if (mapped && !PWRITE) begin
            read_word <= read_of(slot, bank);
         end else begin
            read_word <= 8'h00;
         end
      end
   end

   // A frozen clock enable holds the bus off in the access phase; a read whose setup cycle sees it low returns the old read_word.
   assign PREADY = CE;
   assign PSLVERR = access & ~mapped;
   assign PRDATA = {24'h000000, read_word};

   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         readback <= 8'h00;
      end else if (CE) begin
         if (reg_bleed[`SMAC_BIT_READBACK_SEL]) begin
            readback <= VERSION_DATA;
         end else begin
            readback <= VCO_STATUS_DATA;
         end
      end
   end

   // Masked modulator reset
   // The mask is the value held before the edge, so a write to the mask
   // and a fraction strobe in one cycle still use the old setting.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         mod_reset <= 1'b0;
      end else if (CE) begin
         mod_reset <= FRACTION_WORD_WRITE & ~reg_mod[`SMAC_BIT_RESET_MASK];
      end
   end

   // Half LSB gating
   // Built from the next register value, so the output comes from a flop
   // yet follows the register in the same cycle.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         half_lsb <= RST_HALF;
      end else if (CE) begin
         half_lsb <= next_mod[`SMAC_BIT_HALF_LSB] &
                     ~next_mod[`SMAC_BIT_AUX_ON];
      end
   end

   assign READBACK_DATA = readback;
   assign READBACK_VERSION = reg_bleed[`SMAC_BIT_READBACK_SEL];
   assign BLEED_POSITIVE = reg_bleed[`SMAC_BIT_BLEED_POS];
   assign RESERVED_LATCH_CHOICE = reg_bleed[`SMAC_BIT_LATCH_CHOICE];

   assign MODULATOR_OFF_INTEGER = reg_mod[`SMAC_BIT_MOD_OFF];
   assign AUX_MODULATOR_ON = reg_mod[`SMAC_BIT_AUX_ON];
   assign HALF_LSB_ADD = half_lsb;
   assign MODULATOR_RESET_MASK = reg_mod[`SMAC_BIT_RESET_MASK];
   assign MODULATOR_RESET = mod_reset;

   assign BIAS_LOOP_OFF = reg_core_d[`SMAC_BIT_LOOP_OFF];
   assign TEMP_CAL_VOLTAGE_ON = reg_core_d[`SMAC_BIT_TEMP_CAL];
   assign RECTIFIER_BIAS_CORE_D = reg_core_d[`SMAC_BIT_RECT_D];
   assign LOW_THRESHOLD_CORE_D = reg_core_d[`SMAC_BIT_LOWTHR_D];
   assign THRESHOLD_CODE_CORE_D =
      reg_core_d[`SMAC_THR_D_HI:`SMAC_THR_D_LO];
   assign RECTIFIER_BIAS_CORE_C = reg_core_c[`SMAC_BIT_RECT_CB];
   assign LOW_THRESHOLD_CORE_C = reg_core_c[`SMAC_BIT_LOWTHR_CB];
   assign THRESHOLD_CODE_CORE_C =
      reg_core_c[`SMAC_THR_CB_HI:`SMAC_THR_CB_LO];
   assign RECTIFIER_BIAS_CORE_B = reg_core_b[`SMAC_BIT_RECT_CB];
   assign LOW_THRESHOLD_CORE_B = reg_core_b[`SMAC_BIT_LOWTHR_CB];
   assign THRESHOLD_CODE_CORE_B =
      reg_core_b[`SMAC_THR_CB_HI:`SMAC_THR_CB_LO];

endmodule // smac_config_regs

// *** logic/smac_regs.vh ***
// Register map and field constants for the modulator and bias-loop bank.
`ifndef SMAC_REGS_VH
`define SMAC_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define SMAC_IDX_BLEED 6'h2a
`define SMAC_IDX_MOD 6'h2b
`define SMAC_IDX_CORE_D 6'h2c
`define SMAC_IDX_CORE_C 6'h2d
`define SMAC_IDX_CORE_B 6'h2e
`define SMAC_SLOTS 5
`define SMAC_SLOT_BLEED 3'h0
`define SMAC_SLOT_MOD 3'h1
`define SMAC_SLOT_CORE_D 3'h2
`define SMAC_SLOT_CORE_C 3'h3
`define SMAC_SLOT_CORE_B 3'h4
`define SMAC_SLOT_NONE 3'h7

// Reset values.
`define SMAC_RST_BLEED 8'h00
`define SMAC_RST_MOD 8'h01
`define SMAC_RST_CORE_D 8'h44
`define SMAC_RST_CORE_C 8'h11
`define SMAC_RST_CORE_B 8'h10

// Writable bits; all others are reserved and read as zero.
`define SMAC_WMASK_BLEED 8'h29
`define SMAC_WMASK_MOD 8'h35
`define SMAC_WMASK_CORE_D 8'h7f
`define SMAC_WMASK_CORE_C 8'h1f
`define SMAC_WMASK_CORE_B 8'h1f

// Field positions in the bleed and readback register.
`define SMAC_BIT_READBACK_SEL 0
`define SMAC_BIT_LATCH_CHOICE 3
`define SMAC_BIT_BLEED_POS 5
// Field positions in the modulator register.
`define SMAC_BIT_MOD_OFF 0
`define SMAC_BIT_RESET_MASK 2
`define SMAC_BIT_AUX_ON 4
`define SMAC_BIT_HALF_LSB 5
// Field positions in the core D register.
`define SMAC_BIT_LOOP_OFF 0
`define SMAC_BIT_TEMP_CAL 1
`define SMAC_THR_D_HI 4
`define SMAC_THR_D_LO 2
`define SMAC_BIT_LOWTHR_D 5
`define SMAC_BIT_RECT_D 6
// Field positions in the core C and core B registers.
`define SMAC_THR_CB_HI 2
`define SMAC_THR_CB_LO 0
`define SMAC_BIT_LOWTHR_CB 3
`define SMAC_BIT_RECT_CB 4

`endif
